// File: inc/uart_frame_map.svh
`ifndef UART_FRAME_MAP_SVH
`define UART_FRAME_MAP_SVH
`define ADDR_RESET_VAL 8'h00
`define MASK_RESET_VAL 8'h00
`define MODE_SHIFT 2'h0
`define MODE_8BIT 2'h1
`endif

// File: inc/uart_frame_pkg.sv
package uart_frame_pkg;
    // receive decision phase
    typedef enum logic {RX_IDLE, RX_WAIT_STOP} rx_state_t;
    // serial mode code {bit0, bit1}
    typedef logic [1:0] mode_t;
endpackage

// File: hdl/uart_frame_check_addr_match.sv
`timescale 1ns/10ps
`include "uart_frame_map.svh"
module uart_frame_check_addr_match #(
    parameter int ADDR_WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // configuration
    input wire logic frameCheckEnable,
    input wire logic multiprocEnable,
    input wire logic serialModeBit1,
    // shared top control bit access
    input wire logic topBitWr,
    input wire logic topBitWrData,
    output logic topBitRdData,
    output logic serialModeBit0,
    output logic framingErrorFlag,
    // address register writes
    input wire logic ownAddrWr,
    input wire logic addrMaskWr,
    input wire logic [ADDR_WIDTH-1:0] addrWrData,
    output logic [ADDR_WIDTH-1:0] ownAddress,
    output logic [ADDR_WIDTH-1:0] addressMask,
    // frame events from the base receiver
    input wire logic lastDataStrobe,
    input wire logic [ADDR_WIDTH-1:0] rxData,
    input wire logic rxNinth,
    input wire logic stopStrobe,
    input wire logic stopBit,
    // receive results
    input wire logic receiveDoneClear,
    output logic receiveDoneFlag,
    output logic receivedNinthBit,
    output logic [ADDR_WIDTH-1:0] rxDataOut,
    output uart_frame_pkg::rx_state_t rxPhase
);
    import uart_frame_pkg::*;

    ////////////////////////////////////////////////////////////////
    // elaboration check: map constants and compare are written for byte addresses
    if (ADDR_WIDTH != 8) begin : g_width_check
        $error("address width must be 8");
    end

    ////////////////////////////////////////////////////////////////
    // address compare, shared by both decision points
    function automatic logic addr_hit(
        input logic [ADDR_WIDTH-1:0] a,
        input logic [ADDR_WIDTH-1:0] own,
        input logic [ADDR_WIDTH-1:0] mask
    );
        logic [ADDR_WIDTH-1:0] bcast;
        logic given;
        logic wide;
        bcast = own | mask;
        given = (((a ^ own) & mask) == '0);
        wide = ((~a & bcast) == '0);
        return given | wide;
    endfunction

    ////////////////////////////////////////////////////////////////
    // registers
    logic sm0Reg; // mode bit 0 behind shared position
    logic feReg; // sticky framing error
    logic [ADDR_WIDTH-1:0] ownReg;
    logic [ADDR_WIDTH-1:0] maskReg;
    logic doneReg; // receive done flag
    logic rb8Reg; // received ninth bit
    logic [ADDR_WIDTH-1:0] dataReg; // accepted data
    logic [ADDR_WIDTH-1:0] holdReg; // data waiting for stop bit
    logic holdNinthReg; // ninth bit waiting for stop
    rx_state_t stateReg;
    rx_state_t stateNext;

    ////////////////////////////////////////////////////////////////
    // mode decode
    mode_t mode;
    logic asyncMode; // modes 1, 2 and 3
    logic nineBit; // modes 2 and 3
    logic fcActive; // framing check in force
    logic mpActive; // address recognition in force
    // shift mode code switches off both receive enhancements below
    assign mode = {sm0Reg, serialModeBit1};
    assign asyncMode = (mode != `MODE_SHIFT);
    assign nineBit = asyncMode && (mode != `MODE_8BIT);
    assign fcActive = frameCheckEnable && asyncMode;
    assign mpActive = multiprocEnable && asyncMode;

    ////////////////////////////////////////////////////////////////
    // decision inputs: fresh data at last bit, held data at stop
    logic [ADDR_WIDTH-1:0] dataSel;
    logic ninthSel; // role of address marker
    logic curMatch;
    logic waitStop; // decision must wait for stop bit
    assign dataSel = lastDataStrobe ? rxData : holdReg;
    // in 8-bit mode the stop bit stands in for the ninth bit
    assign ninthSel = nineBit ? (lastDataStrobe ? rxNinth : holdNinthReg)
                              : stopBit;
    assign curMatch = addr_hit(dataSel, ownReg, maskReg);
    // waiting when checking stops, or 8-bit filtering needs the stop
    assign waitStop = asyncMode && (fcActive || (mpActive && !nineBit));

    ////////////////////////////////////////////////////////////////
    // acceptance
    logic filterOk; // passes address filtering
    logic decideNow; // a decision point this cycle
    logic doneEvent; // raise receive done
    logic feEvent; // invalid stop bit seen
    // non-address frames fail, address frames must match
    assign filterOk = !mpActive || (ninthSel && curMatch);
    assign decideNow = (stateReg == RX_WAIT_STOP) ? stopStrobe
                     : (lastDataStrobe && !waitStop);
    assign doneEvent = decideNow && filterOk;
    assign feEvent = stopStrobe && fcActive && !stopBit;

    ////////////////////////////////////////////////////////////////
    // phase machine
    always_comb begin
        stateNext = stateReg;
        unique case (stateReg)
            RX_IDLE: begin
                if (lastDataStrobe && waitStop) begin
                    stateNext = RX_WAIT_STOP;
                end
            end
            RX_WAIT_STOP: begin
                // only the stop sample ends the wait; a fresh last bit does not change the phase
                if (stopStrobe) begin
                    stateNext = RX_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // shared bit write qualifiers
    logic feWr; // write lands on error flag
    logic sm0Wr; // write lands on mode bit
    logic feNext;
    assign feWr = topBitWr && frameCheckEnable;
    assign sm0Wr = topBitWr && !frameCheckEnable;
    // set wins over a software clear in the same cycle
    assign feNext = feEvent | (feWr ? topBitWrData : feReg);
    assign topBitRdData = frameCheckEnable ? feReg : sm0Reg;

    ////////////////////////////////////////////////////////////////
    // state and control registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stateReg <= RX_IDLE;
            sm0Reg <= 1'b0;
            feReg <= 1'b0;
        end else begin
            stateReg <= stateNext;
            sm0Reg <= sm0Wr ? topBitWrData : sm0Reg;
            feReg <= feNext;
        end
    end

    ////////////////////////////////////////////////////////////////
    // address registers, cleared so every address is accepted
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ownReg <= `ADDR_RESET_VAL;
            maskReg <= `MASK_RESET_VAL;
        end else begin
            if (ownAddrWr) begin
                ownReg <= addrWrData;
            end
            if (addrMaskWr) begin
                maskReg <= addrWrData;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // hold data across the stop bit
    // an 8-bit address can only be judged once its stop bit is in
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            holdReg <= '0;
            holdNinthReg <= 1'b0;
        end else if (lastDataStrobe) begin
            holdReg <= rxData;
            holdNinthReg <= rxNinth;
        end
    end

    ////////////////////////////////////////////////////////////////
    // results; done flag set beats software clear
    logic rb8Stop; // stop bit lands in ninth bit
    assign rb8Stop = stopStrobe && (mode == `MODE_8BIT) && !multiprocEnable;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            doneReg <= 1'b0;
            rb8Reg <= 1'b0;
            dataReg <= '0;
        end else begin
            doneReg <= doneEvent | (doneReg & !receiveDoneClear);
            if (doneEvent) begin
                dataReg <= dataSel;
            end
            if (rb8Stop) begin
                rb8Reg <= stopBit;
            end else if (doneEvent && nineBit) begin
                rb8Reg <= ninthSel;
            end
        end
    end

    assign serialModeBit0 = sm0Reg;
    assign framingErrorFlag = feReg;
    assign ownAddress = ownReg;
    assign addressMask = maskReg;
    assign receiveDoneFlag = doneReg;
    assign receivedNinthBit = rb8Reg;
    assign rxDataOut = dataReg;
    assign rxPhase = stateReg;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_fe_set;
        stopStrobe && fcActive && !stopBit |=> feReg;
    endproperty
    a_fe_set: assert property (p_fe_set) else $error("bad stop not flagged");

    property p_fe_sticky;
        feReg && !feWr |=> feReg;
    endproperty
    a_fe_sticky: assert property (p_fe_sticky) else $error("error flag lost");

    property p_fe_off;
        !feReg && !fcActive && !feWr |=> !feReg;
    endproperty
    a_fe_off: assert property (p_fe_off) else $error("flag set while off");

    property p_done_late;
        lastDataStrobe && fcActive && stateReg == RX_IDLE |-> !doneEvent;
    endproperty
    a_done_late: assert property (p_done_late) else $error("done at data bit");

    property p_shift_plain;
        lastDataStrobe && mode == `MODE_SHIFT |=> doneReg;
    endproperty
    a_shift_plain: assert property (p_shift_plain) else $error("mode 0 filtered");

    property p_match_only;
        doneEvent && mpActive |-> curMatch && ninthSel;
    endproperty
    a_match_only: assert property (p_match_only) else $error("unmatched accepted");

    property p_stop_valid;
        doneEvent && mpActive && mode == `MODE_8BIT |-> stopStrobe && stopBit;
    endproperty
    a_stop_valid: assert property (p_stop_valid) else $error("bad stop accepted");

    property p_zero_any;
        ownReg == '0 && maskReg == '0 |-> curMatch;
    endproperty
    a_zero_any: assert property (p_zero_any) else $error("reset addr refused");

    property p_mask_full;
        maskReg == '1 && dataSel == ownReg |-> curMatch;
    endproperty
    a_mask_full: assert property (p_mask_full) else $error("own addr refused");

    property p_rb8_stop;
        rb8Stop |=> rb8Reg == $past(stopBit);
    endproperty
    a_rb8_stop: assert property (p_rb8_stop) else $error("stop not in ninth");

    property p_mode_guard;
        feWr && !feEvent |=> feReg == $past(topBitWrData) && sm0Reg == $past(sm0Reg);
    endproperty
    a_mode_guard: assert property (p_mode_guard) else $error("mode bit hit");

    property p_data_frame;
        lastDataStrobe && !waitStop && mpActive && nineBit && !rxNinth |-> !doneEvent;
    endproperty
    a_data_frame: assert property (p_data_frame) else $error("data frame passed");

    // done flag only falls on a software clear
    property p_done_sticky;
        doneReg && !receiveDoneClear |=> doneReg;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done flag lost");

    // modes are assumed stable across a frame, so only idle decisions are judged
    property p_mp_off;
        lastDataStrobe && !multiprocEnable && !waitStop && stateReg == RX_IDLE |-> doneEvent;
    endproperty
    a_mp_off: assert property (p_mp_off) else $error("frame filtered while off");

    property p_bcast_hit;
        (~dataSel & (ownReg | maskReg)) == '0 |-> curMatch;
    endproperty
    a_bcast_hit: assert property (p_bcast_hit) else $error("broadcast refused");

    // main scenarios
    c_addr_hit: cover property (doneEvent && mpActive);
    c_fe_seen: cover property (feEvent ##1 feReg);
    c_wait_done: cover property (stateReg == RX_WAIT_STOP ##1 doneReg);
    c_rb8_stop: cover property (rb8Stop && !stopBit);
endmodule

// File: bench/serial_node_model.sv
`timescale 1ns/10ps
module serial_node_model (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // frame request from the bench
    input wire logic sendReq,
    input wire logic [7:0] sendByte,
    input wire logic sendNinth,
    input wire logic sendStop,
    input wire logic [3:0] stopGap,
    output logic busy,
    // frame events toward the block
    output logic lastDataStrobe,
    output logic [7:0] rxData,
    output logic rxNinth,
    output logic stopStrobe,
    output logic stopBit
);
    ////////////////////////////////////////////////////////////
    // quiet line at time zero
    initial begin
        busy = 1'b0;
        lastDataStrobe = 1'b0;
        stopStrobe = 1'b0;
        rxData = 8'h00;
        rxNinth = 1'b0;
        stopBit = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // one frame per request: last data, a gap, then the stop sample
    // values outside strobes are inverted so stale data never matches
    always begin
        @(posedge clk);
        if (nrst && sendReq) begin
            busy <= 1'b1;
            lastDataStrobe <= 1'b1;
            rxData <= sendByte;
            rxNinth <= sendNinth;
            @(posedge clk);
            lastDataStrobe <= 1'b0;
            rxData <= ~sendByte;
            rxNinth <= ~sendNinth;
            repeat (stopGap) @(posedge clk);
            stopStrobe <= 1'b1;
            stopBit <= sendStop;
            @(posedge clk);
            stopStrobe <= 1'b0;
            stopBit <= ~sendStop;
            busy <= 1'b0;
        end
    end
endmodule

// File: bench/uart_frame_check_addr_match_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); nErrors++; end end
module uart_frame_check_addr_match_tb;
    import uart_frame_pkg::*;
    // bench controls and design outputs
    logic clk, nrst, frameCheckEnable, multiprocEnable, serialModeBit1, topBitWr;
    logic topBitWrData, ownAddrWr, addrMaskWr, receiveDoneClear, sendReq, sendNinth, sendStop;
    logic [7:0] addrWrData, sendByte, ownAddress, addressMask, rxData, rxDataOut;
    logic [3:0] stopGap;
    logic topBitRdData, serialModeBit0, framingErrorFlag, lastDataStrobe, rxNinth;
    logic stopStrobe, stopBit, receiveDoneFlag, receivedNinthBit, busy;
    rx_state_t rxPhase;
    int nErrors, samplesChecked;
    ////////////////////////////////////////////////////////////
    uart_frame_check_addr_match #(.ADDR_WIDTH(8)) i_uart_frame_check_addr_match (
        .clk(clk), .nrst(nrst), .frameCheckEnable(frameCheckEnable),
        .multiprocEnable(multiprocEnable), .serialModeBit1(serialModeBit1),
        .topBitWr(topBitWr), .topBitWrData(topBitWrData), .topBitRdData(topBitRdData),
        .serialModeBit0(serialModeBit0), .framingErrorFlag(framingErrorFlag),
        .ownAddrWr(ownAddrWr), .addrMaskWr(addrMaskWr), .addrWrData(addrWrData),
        .ownAddress(ownAddress), .addressMask(addressMask), .lastDataStrobe(lastDataStrobe),
        .rxData(rxData), .rxNinth(rxNinth), .stopStrobe(stopStrobe), .stopBit(stopBit),
        .receiveDoneClear(receiveDoneClear), .receiveDoneFlag(receiveDoneFlag),
        .receivedNinthBit(receivedNinthBit), .rxDataOut(rxDataOut), .rxPhase(rxPhase));
    serial_node_model i_serial_node_model (
        .clk(clk), .nrst(nrst), .sendReq(sendReq), .sendByte(sendByte),
        .sendNinth(sendNinth), .sendStop(sendStop), .stopGap(stopGap), .busy(busy),
        .lastDataStrobe(lastDataStrobe), .rxData(rxData), .rxNinth(rxNinth),
        .stopStrobe(stopStrobe), .stopBit(stopBit));
    ////////////////////////////////////////////////////////////
    // 40 mhz clock
    always #12.5 clk = ~clk;
    // verdict and end of run
    task automatic testDone();
        $display("checks=%0d errors=%0d", samplesChecked, nErrors);
        if (nErrors == 0 && samplesChecked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // mode bit0 goes through the shared top bit, so check is off meanwhile
    task automatic setCfg(input logic b0, b1, fce, mp);
        @(posedge clk);
        frameCheckEnable <= 1'b0;
        topBitWr <= 1'b1;
        topBitWrData <= b0;
        serialModeBit1 <= b1;
        multiprocEnable <= mp;
        @(posedge clk);
        topBitWr <= 1'b0;
        frameCheckEnable <= fce;
    endtask
    // own address then mask, back to back
    task automatic setAddr(input logic [7:0] own, mask);
        @(posedge clk);
        ownAddrWr <= 1'b1;
        addrWrData <= own;
        @(posedge clk);
        ownAddrWr <= 1'b0;
        addrMaskWr <= 1'b1;
        addrWrData <= mask;
        @(posedge clk);
        addrMaskWr <= 1'b0;
    endtask
    // clear done and ask the far node for one frame
    task automatic startFrame(input logic [7:0] b, input logic n, s, input logic [3:0] g);
        @(posedge clk);
        receiveDoneClear <= 1'b1;
        sendReq <= 1'b1;
        sendByte <= b;
        sendNinth <= n;
        sendStop <= s;
        stopGap <= g;
        @(posedge clk);
        receiveDoneClear <= 1'b0;
        sendReq <= 1'b0;
    endtask
    // bounded wait for the frame to finish
    task automatic waitIdle();
        for (int i = 0; i < 50; i++) begin
            @(posedge clk);
            #1;
            if (!busy) return;
        end
        nErrors++;
        testDone();
    endtask
    // full frame with expected done flag
    task automatic rx(input logic [7:0] b, input logic n, s, exp);
        startFrame(b, n, s, 4'h2);
        waitIdle();
        `CHK(receiveDoneFlag, exp)
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {clk, nrst, frameCheckEnable, multiprocEnable, serialModeBit1, topBitWr} = '0;
        {topBitWrData, ownAddrWr, addrMaskWr, receiveDoneClear, sendReq} = '0;
        {sendNinth, sendStop, addrWrData, sendByte, stopGap} = '0;
        nErrors = 0;
        samplesChecked = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        #1;
        `CHK(ownAddress, 8'h00)
        `CHK(addressMask, 8'h00)
        setCfg(1'b1, 1'b1, 1'b0, 1'b1);
        rx(8'h5a, 1'b1, 1'b1, 1'b1);
        `CHK(rxDataOut, 8'h5a)
        setAddr(8'h56, 8'hfc);
        rx(8'h55, 1'b1, 1'b1, 1'b1);
        rx(8'h5a, 1'b1, 1'b1, 1'b0);
        rx(8'hff, 1'b1, 1'b1, 1'b1);
        rx(8'h57, 1'b0, 1'b1, 1'b0);
        `CHK(rxDataOut, 8'hff)
        setAddr(8'hf1, 8'hff);
        rx(8'hf1, 1'b1, 1'b1, 1'b1);
        rx(8'hf0, 1'b1, 1'b1, 1'b0);
        // mode 2 with address recognition: broadcast taken, data frame dropped
        setCfg(1'b1, 1'b0, 1'b0, 1'b1);
        rx(8'hff, 1'b1, 1'b1, 1'b1);
        rx(8'hf1, 1'b0, 1'b1, 1'b0);
        `CHK(rxDataOut, 8'hff)
        // no check, no multiproc: done at last data, bad stop ignored
        setCfg(1'b1, 1'b1, 1'b0, 1'b0);
        startFrame(8'h12, 1'b0, 1'b0, 4'h8);
        repeat (3) @(posedge clk);
        #1;
        `CHK(receiveDoneFlag, 1'b1)
        waitIdle();
        `CHK(framingErrorFlag, 1'b0)
        // check on: done waits for the stop sample
        setCfg(1'b1, 1'b1, 1'b1, 1'b0);
        startFrame(8'h33, 1'b1, 1'b0, 4'h8);
        repeat (3) @(posedge clk);
        #1;
        `CHK(receiveDoneFlag, 1'b0)
        `CHK(rxPhase, RX_WAIT_STOP)
        waitIdle();
        `CHK(receiveDoneFlag, 1'b1)
        `CHK(framingErrorFlag, 1'b1)
        `CHK(topBitRdData, 1'b1)
        rx(8'h34, 1'b1, 1'b1, 1'b1);
        `CHK(framingErrorFlag, 1'b1)
        // software clear lands on the flag, mode bit untouched
        @(posedge clk);
        topBitWr <= 1'b1;
        topBitWrData <= 1'b0;
        @(posedge clk);
        topBitWr <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(framingErrorFlag, 1'b0)
        `CHK(serialModeBit0, 1'b1)
        // 8-bit mode, stop bit stands for the ninth
        setCfg(1'b0, 1'b1, 1'b0, 1'b1);
        rx(8'hf1, 1'b0, 1'b1, 1'b1);
        rx(8'hf1, 1'b1, 1'b0, 1'b0);
        rx(8'h22, 1'b0, 1'b1, 1'b0);
        setCfg(1'b0, 1'b1, 1'b0, 1'b0);
        rx(8'h22, 1'b1, 1'b0, 1'b1);
        `CHK(receivedNinthBit, 1'b0)
        rx(8'h23, 1'b0, 1'b1, 1'b1);
        `CHK(receivedNinthBit, 1'b1)
        // shift mode: multiproc and check have no effect
        setCfg(1'b0, 1'b0, 1'b1, 1'b1);
        rx(8'h99, 1'b0, 1'b0, 1'b1);
        `CHK(framingErrorFlag, 1'b0)
        // reset in mid-run: written addresses and flags return to zero
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        #1;
        `CHK(ownAddress, 8'h00)
        `CHK(addressMask, 8'h00)
        `CHK(receiveDoneFlag, 1'b0)
        testDone();
    end
endmodule
